// *** include/cfb_map.svh ***
// offsets, field positions, reset values and limits of the configuration fuse bank
`ifndef CFB_MAP_SVH
`define CFB_MAP_SVH
// How it works
// R1 - three postscale bits pick watchdog ratio 1:1 at 000 up to 1:128 at 111
// R2 - hardware enable set forces watchdog on; clear leaves it to software enable bit
// R3 - unimplemented configuration bit positions always read back as zero
// R4 - low-voltage programming entry allowed only while its enable bit is one
// R5 - stack full or underflow resets the device only when its enable bit is one
// R6 - block 3 protect bit zero protects 006000h to 007FFFh; one leaves it open
// R7 - every implemented configuration bit reads one while the device is unprogrammed
// R8 - settings are latched once at reset release and held during operation

// ----------------------------------------
// word indices (byte address = 4 * index)
// ----------------------------------------
`define CFB_IDX_CFG2H 22'h30_0003
`define CFB_IDX_CFG4L 22'h30_0006
`define CFB_IDX_CFG5L 22'h30_0008
`define CFB_IDX_CTRL 22'h30_0010
`define CFB_IDX_STAT 22'h30_0011

// ----------------------------------------
// field positions
// ----------------------------------------
`define CFB_C2H_HW_EN 0
`define CFB_C2H_PS_LSB 1
`define CFB_C4L_STK_RST 0
`define CFB_C4L_LV_PROG 2
`define CFB_C5L_BLK3_PROT 3
`define CFB_CTRL_SW_EN 0
`define CFB_STAT_RUN 0
`define CFB_STAT_LVOK 1
`define CFB_STAT_PROG 2

// ----------------------------------------
// reset values and ranges
// ----------------------------------------
`define CFB_FUSE_ERASED 7'h7F
`define CFB_SW_EN_RST 1'b0
`define CFB_SEL_CFG2H 2'h0
`define CFB_SEL_CFG4L 2'h1
`define CFB_SEL_CFG5L 2'h2
`define CFB_BLK3_LO 21'h00_6000
`define CFB_BLK3_HI 21'h00_7FFF
`endif

// *** include/cfb_pkg.sv ***
// types shared by the configuration fuse bank
package cfb_pkg;
  typedef struct packed {
    logic [2:0] watchdog_postscale_sel;
    logic watchdog_hw_enable;
    logic low_voltage_prog_enable;
    logic stack_fault_reset_enable;
    logic block3_read_protect;
  } cfb_cfg_type;

  typedef struct packed {
    logic hv_entry;
    logic lv_entry;
    logic erase;
    logic strobe;
    logic [1:0] sel;
    logic [7:0] data;
  } cfb_prog_type;

  typedef enum logic [1:0] {
    CFB_LD_WAIT = 2'b00,
    CFB_LD_LOAD = 2'b01,
    CFB_LD_RUN = 2'b10
  } cfb_ld_state_type;
endpackage

// *** rtl/cfb_top.sv ***
// configuration fuse bank: fuse cells, reset-time shadow, watchdog, stack reset, block 3 guard
`timescale 1ns/1ps
`include "cfb_map.svh"
module cfb_top
  import cfb_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic por_n,
  input wire cfb_prog_type prog_pins,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [23:2] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic wdt_tick,
  input wire logic wdt_clear,
  input wire logic stack_full,
  input wire logic stack_underflow,
  input wire logic pm_rd_req,
  input wire logic [20:0] pm_rd_addr,
  output cfb_cfg_type cfg_out,
  output logic wdt_timeout,
  output logic stack_reset_req,
  output logic pm_rd_blocked,
  output logic lv_entry_ok
);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic [7:0] ps_limit(input logic [2:0] sel);
    ps_limit = 8'((9'h001 << sel) - 9'h001);
  endfunction

  function automatic logic [7:0] cfg_byte(input logic [21:0] idx, input cfb_cfg_type c);
    cfg_byte = 8'h00;
    case (idx)
      `CFB_IDX_CFG2H: begin
        cfg_byte[`CFB_C2H_PS_LSB +: 3] = c.watchdog_postscale_sel;
        cfg_byte[`CFB_C2H_HW_EN] = c.watchdog_hw_enable;
      end
      `CFB_IDX_CFG4L: begin
        cfg_byte[`CFB_C4L_LV_PROG] = c.low_voltage_prog_enable;
        cfg_byte[`CFB_C4L_STK_RST] = c.stack_fault_reset_enable;
      end
      `CFB_IDX_CFG5L: begin
        cfg_byte[`CFB_C5L_BLK3_PROT] = c.block3_read_protect;
      end
      default: begin
        cfg_byte = 8'h00;
      end
    endcase
  endfunction

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_s1_q;
  logic rst_n_q;
  logic por_s1_q;
  logic por_n_q;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // fuse cells follow power-on only, so a plain reset keeps what was programmed
  always_ff @(posedge mclk or negedge por_n) begin
    if (!por_n) begin
      por_s1_q <= 1'b0;
      por_n_q <= 1'b0;
    end else begin
      por_s1_q <= 1'b1;
      por_n_q <= por_s1_q;
    end
  end

  // ----------------------------------------
  // programmer pin synchronisers
  // ----------------------------------------
  localparam int PW = $bits(cfb_prog_type);
  logic [PW-1:0] pin_s1_q;
  logic [PW-1:0] pin_s2_q;
  cfb_prog_type pin;
  logic strobe_prev_q;

  for (genvar i = 0; i < PW; i++) begin : g_sync
    always_ff @(posedge mclk or negedge rst_n_q) begin
      if (!rst_n_q) begin
        pin_s1_q[i] <= 1'b0;
        pin_s2_q[i] <= 1'b0;
      end else begin
        pin_s1_q[i] <= prog_pins[i];
        pin_s2_q[i] <= pin_s1_q[i];
      end
    end
  end

  assign pin = cfb_prog_type'(pin_s2_q);

  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      strobe_prev_q <= 1'b0;
    end else begin
      strobe_prev_q <= pin.strobe;
    end
  end

  // ----------------------------------------
  // fuse cells
  // ----------------------------------------
  cfb_cfg_type fuse_q;
  cfb_cfg_type cfg_q;
  logic prog_active;
  logic prog_go;

  // low-voltage entry needs the latched enable; high-voltage entry is always open
  assign prog_active = pin.hv_entry | (pin.lv_entry & cfg_q.low_voltage_prog_enable); // [R4]
  assign prog_go = prog_active & pin.strobe & ~strobe_prev_q;

  // programming only clears cells; only erase or power-on reset brings them back to one
  always_ff @(posedge mclk or negedge por_n_q) begin
    if (!por_n_q) begin
      fuse_q <= cfb_cfg_type'(`CFB_FUSE_ERASED); // [R7]
    end else if (prog_go) begin
      if (pin.erase) begin
        fuse_q <= cfb_cfg_type'(`CFB_FUSE_ERASED); // [R7]
      end else begin
        case (pin.sel)
          `CFB_SEL_CFG2H: begin
            fuse_q.watchdog_postscale_sel <= fuse_q.watchdog_postscale_sel & pin.data[`CFB_C2H_PS_LSB +: 3];
            fuse_q.watchdog_hw_enable <= fuse_q.watchdog_hw_enable & pin.data[`CFB_C2H_HW_EN];
          end
          `CFB_SEL_CFG4L: begin
            fuse_q.low_voltage_prog_enable <= fuse_q.low_voltage_prog_enable & pin.data[`CFB_C4L_LV_PROG];
            fuse_q.stack_fault_reset_enable <= fuse_q.stack_fault_reset_enable & pin.data[`CFB_C4L_STK_RST];
          end
          `CFB_SEL_CFG5L: begin
            fuse_q.block3_read_protect <= fuse_q.block3_read_protect & pin.data[`CFB_C5L_BLK3_PROT];
          end
          default: begin
            fuse_q <= fuse_q;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // shadow loaded at reset release
  // ----------------------------------------
  cfb_ld_state_type ld_q;

  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ld_q <= CFB_LD_WAIT;
    end else begin
      case (ld_q)
        CFB_LD_WAIT: ld_q <= CFB_LD_LOAD;
        CFB_LD_LOAD: ld_q <= CFB_LD_RUN;
        CFB_LD_RUN: ld_q <= CFB_LD_RUN;
        default: ld_q <= CFB_LD_WAIT;
      endcase
    end
  end

  // programming after the load only shows at the next reset
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cfg_q <= cfb_cfg_type'(`CFB_FUSE_ERASED);
    end else if (ld_q == CFB_LD_LOAD) begin
      cfg_q <= fuse_q; // [R8]
    end
  end

  assign cfg_out = cfg_q;

  // ----------------------------------------
  // watchdog postscaler
  // ----------------------------------------
  logic sw_en_q;
  logic wdt_run;
  logic [7:0] ps_cnt_q;
  logic [7:0] ps_lim;

  assign wdt_run = cfg_q.watchdog_hw_enable | sw_en_q; // [R2]
  assign ps_lim = ps_limit(cfg_q.watchdog_postscale_sel); // [R1]

  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ps_cnt_q <= 8'h00;
      wdt_timeout <= 1'b0;
    end else begin
      wdt_timeout <= 1'b0;
      if (!wdt_run || wdt_clear) begin
        ps_cnt_q <= 8'h00;
      end else if (wdt_tick) begin
        if (ps_cnt_q >= ps_lim) begin
          ps_cnt_q <= 8'h00;
          wdt_timeout <= 1'b1; // [R1]
        end else begin
          ps_cnt_q <= ps_cnt_q + 8'h01;
        end
      end
    end
  end

  // ----------------------------------------
  // stack fault reset and block 3 guard
  // ----------------------------------------
  logic in_blk3;

  assign in_blk3 = (pm_rd_addr >= `CFB_BLK3_LO) && (pm_rd_addr <= `CFB_BLK3_HI);

  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      stack_reset_req <= 1'b0;
    end else begin
      stack_reset_req <= cfg_q.stack_fault_reset_enable & (stack_full | stack_underflow); // [R5]
    end
  end

  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pm_rd_blocked <= 1'b0;
    end else begin
      pm_rd_blocked <= pm_rd_req & in_blk3 & ~cfg_q.block3_read_protect; // [R6]
    end
  end

  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      lv_entry_ok <= 1'b0;
    end else begin
      lv_entry_ok <= pin.lv_entry & cfg_q.low_voltage_prog_enable; // [R4]
    end
  end

  // ----------------------------------------
  // wishbone slave
  // ----------------------------------------
  logic req;
  logic [7:0] stat;

  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign stat = {5'h00, prog_active, lv_entry_ok, wdt_run};

  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // unmapped words and unimplemented bits read zero
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !wb_we_i) begin
      case (wb_adr_i)
        `CFB_IDX_CTRL: wb_dat_o <= {31'h0000_0000, sw_en_q};
        `CFB_IDX_STAT: wb_dat_o <= {24'h00_0000, stat};
        default: wb_dat_o <= {24'h00_0000, cfg_byte(wb_adr_i, cfg_q)}; // [R3]
      endcase
    end
  end

  // fuse words are read-only to software; writes there are acked and dropped
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sw_en_q <= `CFB_SW_EN_RST;
    end else if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == `CFB_IDX_CTRL) begin
      sw_en_q <= wb_dat_i[`CFB_CTRL_SW_EN]; // [R2]
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n_q);

  a_ps_ratio_hit: assert property (wdt_run && !wdt_clear && wdt_tick && ps_cnt_q == ps_lim |=> wdt_timeout) // [R1]
    else $error("postscaler missed its terminal count");
  a_ps_ratio_early: assert property (wdt_timeout |-> $past(ps_cnt_q) == ps_limit(cfg_q.watchdog_postscale_sel)) // [R1]
    else $error("watchdog timeout before selected ratio");
  a_wdt_hw_force: assert property (cfg_q.watchdog_hw_enable |-> wdt_run) // [R2]
    else $error("hardware enable did not force watchdog");
  a_wdt_sw_ctrl: assert property (!cfg_q.watchdog_hw_enable && !sw_en_q |=> !wdt_timeout) // [R2]
    else $error("watchdog ran without any enable");
  a_unimpl_read_zero: assert property (wb_ack_o && !$past(wb_we_i) |-> wb_dat_o[31:8] == 24'h00_0000 && // [R3]
    ($past(wb_adr_i) != `CFB_IDX_CFG2H || wb_dat_o[7:4] == 4'h0))
    else $error("unimplemented bits read nonzero");
  a_lvp_entry_gate: assert property (!cfg_q.low_voltage_prog_enable && !pin.hv_entry |-> !prog_active) // [R4]
    else $error("low-voltage entry accepted while disabled");
  a_stack_reset_on: assert property (cfg_q.stack_fault_reset_enable && (stack_full || stack_underflow) // [R5]
    |=> stack_reset_req)
    else $error("stack fault did not request reset");
  a_stack_reset_off: assert property (!cfg_q.stack_fault_reset_enable |=> !stack_reset_req) // [R5]
    else $error("stack reset while disabled");
  a_blk3_protect: assert property (pm_rd_req && in_blk3 && !cfg_q.block3_read_protect |=> pm_rd_blocked) // [R6]
    else $error("block 3 read not blocked");
  a_blk3_open: assert property (cfg_q.block3_read_protect && $stable(cfg_q) |=> !pm_rd_blocked) // [R6]
    else $error("block 3 blocked while unprotected");
  a_erase_ones: assert property (prog_go && pin.erase |=> fuse_q == cfb_cfg_type'(`CFB_FUSE_ERASED)) // [R7]
    else $error("erase left a cell programmed");
  a_cfg_hold: assert property (ld_q == CFB_LD_RUN |=> $stable(cfg_q)) // [R8]
    else $error("settings changed during operation");

  c_wdt_timeout: cover property (wdt_run ##1 wdt_timeout);
  c_stack_reset: cover property (stack_reset_req);
  c_blk3_block: cover property (pm_rd_blocked);
  c_lv_program: cover property (prog_go && pin.lv_entry && !pin.hv_entry);

endmodule // cfb_top

// *** tb/cfb_prog_model.sv ***
// behavioural model of the external programmer that burns configuration cells
`timescale 1ns/1ps
module cfb_prog_model
  import cfb_pkg::*;
(
  input wire logic mclk,
  output cfb_prog_type pins
);
  initial pins = '{1'b0, 1'b0, 1'b0, 1'b0, 2'h3, 8'hFF};

  // one byte per strobe, with select and data held well around the strobe edge
  task automatic op(input logic hv, input logic lv, input logic er, input logic [1:0] sel, input logic [7:0] data);
    @(posedge mclk);
    pins <= '{hv, lv, er, 1'b0, sel, data};
    repeat (4) @(posedge mclk);
    pins.strobe <= 1'b1;
    repeat (6) @(posedge mclk);
    pins.strobe <= 1'b0;
    repeat (4) @(posedge mclk);
    // released data lines flip so a stale byte is never mistaken for a held one
    pins <= '{1'b0, 1'b0, 1'b0, 1'b0, 2'h3, ~data};
    repeat (3) @(posedge mclk);
  endtask

  task automatic burn(input logic hv, input logic lv, input logic [1:0] sel, input logic [7:0] data);
    op(hv, lv, 1'b0, sel, data);
  endtask

  // erase goes in over high-voltage entry so it never hangs on the latched enable
  task automatic wipe();
    op(1'b1, 1'b0, 1'b1, 2'h0, 8'hFF);
  endtask
endmodule // cfb_prog_model

// *** tb/test_config_fuse_bits.sv ***
// self-checking bench for the configuration fuse bank
`timescale 1ns/1ps
`include "cfb_map.svh"
module test_config_fuse_bits;
  import cfb_pkg::*;
  logic mclk = 1'b0, rstn = 1'b0, por_n = 1'b0;
  cfb_prog_type prog_pins;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [23:2] wb_adr_i = '0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = '0, wb_dat_o;
  logic wb_ack_o, wdt_tick = 1'b0, wdt_clear = 1'b0, stack_full = 1'b0, stack_underflow = 1'b0;
  logic pm_rd_req = 1'b0, wdt_timeout, stack_reset_req, pm_rd_blocked, lv_entry_ok, rq, bl;
  logic [20:0] pm_rd_addr = '0;
  cfb_cfg_type cfg_out;
  logic [31:0] expq [$];
  logic [31:0] seed = 32'h0472;
  int fail_count = 0, n_compared = 0, n_to = 0, n_lv = 0;

  always #50 mclk = ~mclk;

  cfb_top cfb_top_inst (.mclk(mclk), .rstn(rstn), .por_n(por_n), .prog_pins(prog_pins),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wdt_tick(wdt_tick), .wdt_clear(wdt_clear), .stack_full(stack_full),
    .stack_underflow(stack_underflow), .pm_rd_req(pm_rd_req), .pm_rd_addr(pm_rd_addr),
    .cfg_out(cfg_out), .wdt_timeout(wdt_timeout), .stack_reset_req(stack_reset_req),
    .pm_rd_blocked(pm_rd_blocked), .lv_entry_ok(lv_entry_ok));
  cfb_prog_model cfb_prog_model_inst (.mclk(mclk), .pins(prog_pins));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (fail_count == 0 && n_compared > 0 && expq.size() == 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wb(input logic we, input logic [23:2] adr, input logic [31:0] dat);
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'h1;
    wb_dat_i <= dat;
    // no cycle count is assumed; only the watchdog ends a wait that never sees ack
    do @(posedge mclk); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic rd(input logic [23:2] adr, input logic [31:0] exp);
    expq.push_back(exp);
    wb(1'b0, adr, 32'h0);
  endtask

  task automatic pulse(input logic sf, input logic su, input logic pr, input logic [20:0] a);
    @(posedge mclk);
    stack_full <= sf;
    stack_underflow <= su;
    pm_rd_req <= pr;
    pm_rd_addr <= a;
    @(posedge mclk);
    stack_full <= 1'b0;
    stack_underflow <= 1'b0;
    pm_rd_req <= 1'b0;
    pm_rd_addr <= ~a;
    @(posedge mclk);
    rq = stack_reset_req;
    bl = pm_rd_blocked;
  endtask

  task automatic pm_sweep(input logic prot);
    logic [20:0] a [6];
    a = '{21'h006000, 21'h007FFF, 21'h005FFF, 21'h008000, 21'h006000 | 21'($random(seed) & 32'h1FFF),
      21'($random(seed))};
    foreach (a[i]) begin
      pulse(1'b0, 1'b0, 1'b1, a[i]);
      check(32'(bl), 32'(prot && a[i] >= `CFB_BLK3_LO && a[i] <= `CFB_BLK3_HI));
    end
  endtask

  task automatic ticks(input int n, input int exp);
    n_to = 0;
    @(posedge mclk);
    wdt_tick <= 1'b1;
    repeat (n) @(posedge mclk);
    wdt_tick <= 1'b0;
    repeat (3) @(posedge mclk);
    check(32'(n_to), 32'(exp));
  endtask

  task automatic reboot();
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    repeat (8) @(posedge mclk);
  endtask

  // read answers are paired with the oldest note in the order they were asked
  always @(posedge mclk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && expq.size() > 0) check(wb_dat_o, expq.pop_front());
    if (wdt_timeout === 1'b1) n_to++;
    if (lv_entry_ok === 1'b1) n_lv++;
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge mclk);
    por_n <= 1'b1;
    rstn <= 1'b1;
    repeat (8) @(posedge mclk);
    check({25'h0, cfg_out}, 32'h7F);
    rd(`CFB_IDX_CFG2H, 32'h0F);
    rd(`CFB_IDX_CFG4L, 32'h05);
    rd(`CFB_IDX_CFG5L, 32'h08);
    rd(22'h30_0004, 32'h0);
    wb(1'b1, `CFB_IDX_CFG2H, 32'h0);
    rd(`CFB_IDX_CFG2H, 32'h0F);
    pulse(1'b1, 1'b0, 1'b0, 21'h0);
    check(32'(rq), 32'h1);
    pulse(1'b0, 1'b1, 1'b0, 21'h0);
    check(32'(rq), 32'h1);
    pm_sweep(1'b0);
    ticks(256, 2);
    cfb_prog_model_inst.burn(1'b1, 1'b0, `CFB_SEL_CFG2H, 8'h04);
    cfb_prog_model_inst.burn(1'b1, 1'b0, `CFB_SEL_CFG4L, 8'h00);
    cfb_prog_model_inst.burn(1'b0, 1'b1, `CFB_SEL_CFG5L, 8'h00);
    check(32'(n_lv != 0), 32'h1);
    check({25'h0, cfg_out}, 32'h7F);
    reboot();
    check({25'h0, cfg_out}, 32'h20);
    rd(`CFB_IDX_CFG2H, 32'h04);
    rd(`CFB_IDX_CFG4L, 32'h00);
    rd(`CFB_IDX_CFG5L, 32'h00);
    pulse(1'b1, 1'b1, 1'b0, 21'h0);
    check(32'(rq), 32'h0);
    pm_sweep(1'b1);
    ticks(16, 0);
    wb(1'b1, `CFB_IDX_CTRL, 32'h1);
    rd(`CFB_IDX_CTRL, 32'h1);
    rd(`CFB_IDX_STAT, 32'h1);
    ticks(16, 4);
    // a clear part-way through a period restarts it, so one more tick must not time out
    ticks(3, 0);
    @(posedge mclk) wdt_clear <= 1'b1;
    @(posedge mclk) wdt_clear <= 1'b0;
    ticks(1, 0);
    // low-voltage entry must now be refused, so the cells keep their value
    n_lv = 0;
    cfb_prog_model_inst.burn(1'b0, 1'b1, `CFB_SEL_CFG2H, 8'h00);
    reboot();
    check(32'(n_lv), 32'h0);
    rd(`CFB_IDX_CFG2H, 32'h04);
    cfb_prog_model_inst.wipe();
    reboot();
    check({25'h0, cfg_out}, 32'h7F);
    repeat (2) @(posedge mclk);
    conclude();
  end

  initial begin
    repeat (6000) @(posedge mclk);
    fail_count++;
    conclude();
  end
endmodule // test_config_fuse_bits
